// File: dmx_pkg.sv
// Shared constants and types for the data move, exchange and stack unit
package dmx_pkg;
   localparam int XLEN = 32;
   localparam int AW = 8;
   // Register map, byte addresses
   localparam logic [7:0] OFF_GPR = 8'h00;
   localparam logic [7:0] OFF_FLAGS = 8'h20;
   localparam logic [7:0] OFF_CMD = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_MADDR = 8'h2C;
   localparam logic [7:0] OFF_IMM = 8'h30;
   localparam logic [31:0] GPR_RST = 32'h0000_0000;
   localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] MADDR_RST = 32'h0000_0000;
   // Flag bit positions
   localparam int FL_CF = 0;
   localparam int FL_PF = 2;
   localparam int FL_AF = 4;
   localparam int FL_ZF = 6;
   localparam int FL_SF = 7;
   localparam int FL_OF = 11;
   // General register indices, also the push_all order
   localparam logic [2:0] IX_ACC = 3'h0;
   localparam logic [2:0] IX_CNT = 3'h1;
   localparam logic [2:0] IX_DAT = 3'h2;
   localparam logic [2:0] IX_BASE = 3'h3;
   localparam logic [2:0] IX_SP = 3'h4;
   localparam logic [2:0] IX_LAST = 3'h7;
   localparam logic [31:0] STEP32 = 32'h0000_0004;
   localparam logic [31:0] STEP16 = 32'h0000_0002;
   localparam logic [31:0] HI_OFS = 32'h0000_0004;

   typedef enum logic [3:0] {
      OP_BYTE_ORDER_REVERSE = 4'h0, OP_CMOV = 4'h1, OP_EXCHANGE_ADD = 4'h2, OP_CX = 4'h3,
      OP_CX64 = 4'h4, OP_PUSH = 4'h5, OP_POP = 4'h6, OP_PUSH_ALL = 4'h7,
      OP_POP_ALL = 4'h8, OP_CBW = 4'h9, OP_WORD_TO_DWORD_EXTEND = 4'hA
   } dmx_op_t;

   typedef enum logic [3:0] {
      CC_O = 4'h0, CC_NO = 4'h1, CC_B = 4'h2, CC_AE = 4'h3,
      CC_E = 4'h4, CC_NE = 4'h5, CC_BE = 4'h6, CC_A = 4'h7,
      CC_S = 4'h8, CC_NS = 4'h9, CC_P = 4'hA, CC_NP = 4'hB,
      CC_L = 4'hC, CC_GE = 4'hD, CC_LE = 4'hE, CC_G = 4'hF
   } dmx_cc_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001, S_MRD = 3'b010, S_MWR = 3'b100
   } dmx_state_t;

   // Command word, low bits first: op, cc, dst, src, use_imm, size16, lock
   typedef struct packed {
      logic lock;
      logic size16;
      logic use_imm;
      logic [2:0] src;
      logic [2:0] dst;
      dmx_cc_t cc;
      dmx_op_t op;
   } dmx_cmd_t;

   typedef struct packed {
      logic req;
      logic we;
      logic lock;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dmx_mem_t;
endpackage : dmx_pkg

// File: dmx_cond.sv
// Condition evaluation for conditional_move
`timescale 1ns/1ns
module dmx_cond (
   input wire dmx_pkg::dmx_cc_t cc, // Condition code
   input wire logic [31:0] flags, // Current flags
   output logic ok // Condition holds
);
   wire cf = flags[dmx_pkg::FL_CF];
   wire zf = flags[dmx_pkg::FL_ZF];
   wire sf = flags[dmx_pkg::FL_SF];
   wire of = flags[dmx_pkg::FL_OF];
   wire pf = flags[dmx_pkg::FL_PF];
   wire lt = sf ^ of;

   always_comb begin
      case (cc)
         dmx_pkg::CC_O: ok = of;
         dmx_pkg::CC_NO: ok = ~of;
         dmx_pkg::CC_B: ok = cf;
         dmx_pkg::CC_AE: ok = ~cf;
         dmx_pkg::CC_E: ok = zf;
         dmx_pkg::CC_NE: ok = ~zf;
         dmx_pkg::CC_BE: ok = cf | zf;
         dmx_pkg::CC_A: ok = ~(cf | zf);
         dmx_pkg::CC_S: ok = sf;
         dmx_pkg::CC_NS: ok = ~sf;
         dmx_pkg::CC_P: ok = pf;
         dmx_pkg::CC_NP: ok = ~pf;
         dmx_pkg::CC_L: ok = lt;
         dmx_pkg::CC_GE: ok = ~lt;
         dmx_pkg::CC_LE: ok = lt | zf;
         dmx_pkg::CC_G: ok = ~(lt | zf);
         default: ok = 1'b0;
      endcase
   end
endmodule : dmx_cond

// File: dmx_addsub.sv
// 32-bit adder/subtractor with status flag update
`timescale 1ns/1ns
module dmx_addsub (
   input wire logic [31:0] a, // First operand
   input wire logic [31:0] b, // Second operand
   input wire logic sub, // 1 computes a - b
   input wire logic [31:0] fl_in, // Flags before
   output logic [31:0] res, // Result
   output logic [31:0] fl_out // Flags after
);
   wire [32:0] full = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
   wire same = (a[31] == b[31]);
   wire ovf = (sub ? ~same : same) & (full[31] != a[31]);

   assign res = full[31:0];

   always_comb begin
      fl_out = fl_in;
      fl_out[dmx_pkg::FL_CF] = full[32];
      fl_out[dmx_pkg::FL_PF] = ~^full[7:0];
      fl_out[dmx_pkg::FL_AF] = a[4] ^ b[4] ^ full[4];
      fl_out[dmx_pkg::FL_ZF] = (full[31:0] == 32'h0000_0000);
      fl_out[dmx_pkg::FL_SF] = full[31];
      fl_out[dmx_pkg::FL_OF] = ovf;
   end
endmodule : dmx_addsub

// File: dmx_unit.sv
// Data move, exchange and stack execution unit with register port and memory port
// Behaviour
// - byte 0 swaps with byte 3
// - byte 1 swaps with byte 2
// - above needs CF|ZF clear, below-equal set
// - above-equal/not-carry moves when CF clear
// - below/carry moves when CF set
// - greater-equal moves when SF^OF clear
// - less moves when SF^OF set
// - less-equal on (SF^OF)|ZF; greater inverse
// - exchange_add swaps then writes sum
// - exchange_add flags from the addition
// - compare equal stores source into destination
// - compare unequal loads destination into accumulator
// - compare flags as accumulator minus destination
// - 64-bit equal stores count:base pair
// - 64-bit unequal loads data_ext:accumulator pair
// - locked compare keeps bus locked throughout
// - push decrements pointer then writes
// - push_all order with original pointer
// - pop reads top then increments pointer
// - pop_all 32-bit order, one discarded
// - pop_all 16-bit order, one discarded
// - byte_to_word copies bit 7 upward
// - word_to_dword copies bit 15 upward
`timescale 1ns/1ns
module dmx_unit (
   input wire logic ref_clk, // 20 MHz clock
   input wire logic rst, // Synchronous reset, high
   input wire logic [7:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after strobe
   output dmx_pkg::dmx_mem_t mem_o, // Memory request
   input wire logic mem_ack, // Memory beat done
   input wire logic [31:0] mem_rdata // Read data with ack
);
   logic [31:0] gpr_q [8];
   logic [31:0] flags_q;
   logic [31:0] maddr_q;
   logic [31:0] imm_q;
   logic [31:0] tmp_q;
   logic [31:0] tmp_d;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic eq_q;
   logic eq_d;
   logic cond_q;
   dmx_pkg::dmx_cmd_t cmd_q;
   dmx_pkg::dmx_state_t st_q;
   dmx_pkg::dmx_state_t st_d;
   dmx_pkg::dmx_mem_t mem_d;
   logic wa_en;
   logic [2:0] wa_ix;
   logic [31:0] wa_v;
   logic wb_en;
   logic [2:0] wb_ix;
   logic [31:0] wb_v;
   logic fl_en;
   logic [31:0] fl_d;

   function automatic logic [31:0] merge16(input logic [31:0] old, input logic [31:0] nv,
                                           input logic s16);
      merge16 = s16 ? {old[31:16], nv[15:0]} : nv;
   endfunction : merge16

   // Register decode
   wire idle = (st_q == dmx_pkg::S_IDLE);
   wire is_gpr = (reg_addr[7:5] == dmx_pkg::OFF_GPR[7:5]);
   wire [2:0] gix = reg_addr[4:2];
   wire start = reg_wr & idle & (reg_addr == dmx_pkg::OFF_CMD);
   wire dmx_pkg::dmx_cmd_t cmd_in = dmx_pkg::dmx_cmd_t'(reg_wdata[16:0]);
   // Commands written while busy are dropped; software polls the busy bit first
   wire dmx_pkg::dmx_cmd_t cmd = start ? cmd_in : cmd_q;
   wire [31:0] step = cmd.size16 ? dmx_pkg::STEP16 : dmx_pkg::STEP32;
   wire [31:0] sp = gpr_q[dmx_pkg::IX_SP];
   wire [31:0] acc = gpr_q[dmx_pkg::IX_ACC];
   wire [31:0] dv = gpr_q[cmd.dst];
   wire [31:0] sv = cmd.use_imm ? imm_q : gpr_q[cmd.src];
   wire [31:0] sp_dn = sp - step;
   wire [31:0] sp_up = sp + step;
   wire [31:0] bsw = {dv[7:0], dv[15:8], dv[23:16], dv[31:24]};
   wire [31:0] byte_to_word_extend = {acc[31:16], {8{acc[7]}}, acc[7:0]};
   wire [31:0] word_to_dword_extend = {{16{acc[15]}}, acc[15:0]};
   wire [2:0] cnt_nx = cnt_q + 3'h1;
   wire [2:0] pop_ix = dmx_pkg::IX_LAST - cnt_q;
   wire [31:0] psh_v = (cnt_nx == dmx_pkg::IX_SP) ? tmp_q : gpr_q[cnt_nx];
   wire [31:0] hi_adr = maddr_q + dmx_pkg::HI_OFS;
   wire in_rd = (st_q == dmx_pkg::S_MRD);
   wire eq32 = (acc == mem_rdata);
   wire eq64 = ({gpr_q[dmx_pkg::IX_DAT], acc} == {mem_rdata, tmp_q});
   wire cond_ok;
   wire [31:0] alu_r;
   wire [31:0] alu_fl;

   dmx_cond u_cond (
      .cc(cmd.cc),
      .flags(flags_q),
      .ok(cond_ok)
   );

   // Memory phase compares accumulator minus destination, register phase adds
   dmx_addsub u_alu (
      .a(in_rd ? acc : dv),
      .b(in_rd ? mem_rdata : sv),
      .sub(in_rd),
      .fl_in(flags_q),
      .res(alu_r),
      .fl_out(alu_fl)
   );

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      tmp_d = tmp_q;
      eq_d = eq_q;
      mem_d = mem_o;
      wa_en = 1'b0;
      wa_ix = cmd.dst;
      wa_v = 32'h0000_0000;
      wb_en = 1'b0;
      wb_ix = dmx_pkg::IX_SP;
      wb_v = sp_dn;
      fl_en = 1'b0;
      fl_d = alu_fl;
      if (mem_ack) begin
         mem_d.req = 1'b0;
      end
      case (st_q)
         dmx_pkg::S_IDLE: begin
            if (reg_wr & is_gpr) begin
               wa_en = 1'b1;
               wa_ix = gix;
               wa_v = reg_wdata;
            end
            if (start) begin
               cnt_d = 3'h0;
               mem_d.lock = 1'b0;
               case (cmd_in.op)
                  dmx_pkg::OP_BYTE_ORDER_REVERSE: begin
                     wa_en = 1'b1;
                     wa_v = bsw;
                  end
                  dmx_pkg::OP_CMOV: begin
                     wa_en = cond_ok;
                     wa_v = merge16(dv, sv, cmd_in.size16);
                  end
                  dmx_pkg::OP_EXCHANGE_ADD: begin
                     wb_en = 1'b1;
                     wb_ix = cmd_in.src;
                     wb_v = dv;
                     wa_en = 1'b1;
                     wa_v = alu_r;
                     fl_en = 1'b1;
                  end
                  dmx_pkg::OP_CBW: begin
                     wa_en = 1'b1;
                     wa_ix = dmx_pkg::IX_ACC;
                     wa_v = byte_to_word_extend;
                  end
                  dmx_pkg::OP_WORD_TO_DWORD_EXTEND: begin
                     wa_en = 1'b1;
                     wa_ix = dmx_pkg::IX_ACC;
                     wa_v = word_to_dword_extend;
                  end
                  dmx_pkg::OP_CX, dmx_pkg::OP_CX64: begin
                     st_d = dmx_pkg::S_MRD;
                     mem_d = '{req: 1'b1, we: 1'b0, lock: cmd_in.lock, addr: maddr_q, wdata: 32'h0};
                  end
                  dmx_pkg::OP_PUSH: begin
                     wb_en = 1'b1;
                     st_d = dmx_pkg::S_MWR;
                     mem_d = '{req: 1'b1, we: 1'b1, lock: 1'b0, addr: sp_dn,
                               wdata: merge16(32'h0, sv, cmd_in.size16)};
                  end
                  dmx_pkg::OP_PUSH_ALL: begin
                     tmp_d = sp;
                     wb_en = 1'b1;
                     st_d = dmx_pkg::S_MWR;
                     mem_d = '{req: 1'b1, we: 1'b1, lock: 1'b0, addr: sp_dn,
                               wdata: merge16(32'h0, acc, cmd_in.size16)};
                  end
                  dmx_pkg::OP_POP, dmx_pkg::OP_POP_ALL: begin
                     st_d = dmx_pkg::S_MRD;
                     mem_d = '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: sp, wdata: 32'h0};
                  end
                  default: st_d = dmx_pkg::S_IDLE;
               endcase
            end
         end
         dmx_pkg::S_MRD: begin
            if (mem_ack) begin
               case (cmd_q.op)
                  dmx_pkg::OP_CX: begin
                     fl_en = 1'b1;
                     eq_d = eq32;
                     wa_en = ~eq32;
                     wa_ix = dmx_pkg::IX_ACC;
                     wa_v = mem_rdata;
                     st_d = dmx_pkg::S_MWR;
                     // Unequal case writes the old value back so the locked cycle always closes
                     mem_d = '{req: 1'b1, we: 1'b1, lock: cmd_q.lock, addr: maddr_q,
                               wdata: eq32 ? gpr_q[cmd_q.src] : mem_rdata};
                  end
                  dmx_pkg::OP_CX64: begin
                     if (cnt_q == 3'h0) begin
                        tmp_d = mem_rdata;
                        cnt_d = 3'h1;
                        mem_d = '{req: 1'b1, we: 1'b0, lock: cmd_q.lock, addr: hi_adr, wdata: 32'h0};
                     end else begin
                        eq_d = eq64;
                        fl_en = 1'b1;
                        fl_d = flags_q;
                        fl_d[dmx_pkg::FL_ZF] = eq64;
                        wa_en = ~eq64;
                        wa_ix = dmx_pkg::IX_ACC;
                        wa_v = tmp_q;
                        wb_en = ~eq64;
                        wb_ix = dmx_pkg::IX_DAT;
                        wb_v = mem_rdata;
                        tmp_d = mem_rdata;
                        cnt_d = 3'h0;
                        st_d = dmx_pkg::S_MWR;
                        mem_d = '{req: 1'b1, we: 1'b1, lock: cmd_q.lock, addr: maddr_q,
                                  wdata: eq64 ? gpr_q[dmx_pkg::IX_BASE] : tmp_q};
                     end
                  end
                  dmx_pkg::OP_POP: begin
                     wa_en = 1'b1;
                     wa_v = merge16(dv, mem_rdata, cmd_q.size16);
                     wb_en = 1'b1;
                     wb_v = sp_up;
                     st_d = dmx_pkg::S_IDLE;
                  end
                  dmx_pkg::OP_POP_ALL: begin
                     wa_en = (pop_ix != dmx_pkg::IX_SP);
                     wa_ix = pop_ix;
                     wa_v = merge16(gpr_q[pop_ix], mem_rdata, cmd_q.size16);
                     wb_en = 1'b1;
                     wb_v = sp_up;
                     cnt_d = cnt_nx;
                     if (cnt_q == dmx_pkg::IX_LAST) begin
                        st_d = dmx_pkg::S_IDLE;
                     end else begin
                        mem_d = '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: sp_up, wdata: 32'h0};
                     end
                  end
                  default: st_d = dmx_pkg::S_IDLE;
               endcase
            end
         end
         dmx_pkg::S_MWR: begin
            if (mem_ack) begin
               case (cmd_q.op)
                  dmx_pkg::OP_CX64: begin
                     if (cnt_q == 3'h0) begin
                        cnt_d = 3'h1;
                        mem_d = '{req: 1'b1, we: 1'b1, lock: cmd_q.lock, addr: hi_adr,
                                  wdata: eq_q ? gpr_q[dmx_pkg::IX_CNT] : tmp_q};
                     end else begin
                        mem_d.lock = 1'b0;
                        st_d = dmx_pkg::S_IDLE;
                     end
                  end
                  dmx_pkg::OP_PUSH_ALL: begin
                     if (cnt_q == dmx_pkg::IX_LAST) begin
                        st_d = dmx_pkg::S_IDLE;
                     end else begin
                        cnt_d = cnt_nx;
                        wb_en = 1'b1;
                        mem_d = '{req: 1'b1, we: 1'b1, lock: 1'b0, addr: sp_dn,
                                  wdata: merge16(32'h0, psh_v, cmd_q.size16)};
                     end
                  end
                  default: begin
                     mem_d.lock = 1'b0;
                     st_d = dmx_pkg::S_IDLE;
                  end
               endcase
            end
         end
         default: st_d = dmx_pkg::S_IDLE;
      endcase
   end

   // Read-back mux
   wire [31:0] status = {28'h0, cond_q, eq_q, mem_o.lock, ~idle};
   wire [31:0] rd_v = is_gpr ? gpr_q[gix] :
                      (reg_addr == dmx_pkg::OFF_FLAGS) ? flags_q :
                      (reg_addr == dmx_pkg::OFF_CMD) ? {15'h0, cmd_q} :
                      (reg_addr == dmx_pkg::OFF_STATUS) ? status :
                      (reg_addr == dmx_pkg::OFF_MADDR) ? maddr_q :
                      (reg_addr == dmx_pkg::OFF_IMM) ? imm_q : 32'h0000_0000;
   wire cfg_wr = reg_wr & idle;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            gpr_q[i] <= dmx_pkg::GPR_RST;
         end
      end else begin
         if (wb_en) begin
            gpr_q[wb_ix] <= wb_v;
         end
         if (wa_en) begin
            gpr_q[wa_ix] <= wa_v;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flags_q <= dmx_pkg::FLAGS_RST;
         maddr_q <= dmx_pkg::MADDR_RST;
         imm_q <= 32'h0000_0000;
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? rd_v : 32'h0000_0000;
         if (fl_en) begin
            flags_q <= fl_d;
         end else if (cfg_wr && reg_addr == dmx_pkg::OFF_FLAGS) begin
            flags_q <= reg_wdata;
         end
         if (cfg_wr && reg_addr == dmx_pkg::OFF_MADDR) begin
            maddr_q <= reg_wdata;
         end
         if (cfg_wr && reg_addr == dmx_pkg::OFF_IMM) begin
            imm_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= dmx_pkg::S_IDLE;
         cmd_q <= '0;
         cnt_q <= 3'h0;
         tmp_q <= 32'h0000_0000;
         eq_q <= 1'b0;
         cond_q <= 1'b0;
         mem_o <= '0;
      end else begin
         st_q <= st_d;
         cmd_q <= cmd;
         cnt_q <= cnt_d;
         tmp_q <= tmp_d;
         eq_q <= eq_d;
         cond_q <= start ? cond_ok : cond_q;
         mem_o <= mem_d;
      end
   end

   wire st_byte_order_reverse = start && cmd_in.op == dmx_pkg::OP_BYTE_ORDER_REVERSE;
   wire st_cmov = start && cmd_in.op == dmx_pkg::OP_CMOV;

   property p_byte_order_reverse_outer;
      @(posedge ref_clk) disable iff (rst)
      st_byte_order_reverse |=> gpr_q[$past(cmd_in.dst)][7:0] == $past(dv[31:24]);
   endproperty
   a_byte_order_reverse_outer: assert property (p_byte_order_reverse_outer) else $error("outer bytes not swapped");

   property p_byte_order_reverse_inner;
      @(posedge ref_clk) disable iff (rst)
      st_byte_order_reverse |=> gpr_q[$past(cmd_in.dst)][23:16] == $past(dv[15:8]);
   endproperty
   a_byte_order_reverse_inner: assert property (p_byte_order_reverse_inner) else $error("inner bytes not swapped");

   property p_cmov_above;
      @(posedge ref_clk) disable iff (rst)
      cmd.cc == dmx_pkg::CC_A |-> cond_ok == !(flags_q[dmx_pkg::FL_CF] | flags_q[dmx_pkg::FL_ZF]);
   endproperty
   a_cmov_above: assert property (p_cmov_above) else $error("above condition wrong");

   property p_cmov_less;
      @(posedge ref_clk) disable iff (rst)
      cmd.cc == dmx_pkg::CC_L |-> cond_ok == (flags_q[dmx_pkg::FL_SF] ^ flags_q[dmx_pkg::FL_OF]);
   endproperty
   a_cmov_less: assert property (p_cmov_less) else $error("less condition wrong");

   property p_cmov_keep;
      @(posedge ref_clk) disable iff (rst)
      st_cmov && !cond_ok |=> gpr_q[$past(cmd_in.dst)] == $past(dv);
   endproperty
   a_cmov_keep: assert property (p_cmov_keep) else $error("false move changed destination");

   property p_push_sp;
      @(posedge ref_clk) disable iff (rst)
      start && cmd_in.op == dmx_pkg::OP_PUSH |=> sp == $past(sp_dn) && mem_o.addr == sp && mem_o.we;
   endproperty
   a_push_sp: assert property (p_push_sp) else $error("push pointer wrong");

   property p_lock_hold;
      @(posedge ref_clk) disable iff (rst)
      mem_o.req && mem_o.lock |-> (cmd_q.op == dmx_pkg::OP_CX || cmd_q.op == dmx_pkg::OP_CX64) && !idle;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock outside compare sequence");

   property p_cbw;
      @(posedge ref_clk) disable iff (rst)
      start && cmd_in.op == dmx_pkg::OP_CBW |=> acc[15:8] == {8{$past(acc[7])}};
   endproperty
   a_cbw: assert property (p_cbw) else $error("byte sign not extended");

   property p_word_to_dword_extend;
      @(posedge ref_clk) disable iff (rst)
      start && cmd_in.op == dmx_pkg::OP_WORD_TO_DWORD_EXTEND |=> acc[31:16] == {16{$past(acc[15])}};
   endproperty
   a_word_to_dword_extend: assert property (p_word_to_dword_extend) else $error("word sign not extended");
endmodule : dmx_unit

// File: dmx_mem_model.sv
// Memory model answering the unit's memory port after a chosen latency
`timescale 1ns/1ns
module dmx_mem_model (
   input wire logic ref_clk, // Clock
   input wire dmx_pkg::dmx_mem_t mem_o, // Request from the unit
   input wire logic [1:0] lat, // Wait cycles before each ack
   output logic mem_ack, // Beat done
   output logic [31:0] mem_rdata // Read data, only valid with ack
);
   logic [31:0] mem [256];
   logic [31:0] rd_q = 32'h0000_0000;
   logic [1:0] cnt = 2'h0;
   initial mem_ack = 1'b0;
   // Outside an ack the line shows the inverse, so a late sample cannot pass
   assign mem_rdata = mem_ack ? rd_q : ~rd_q;
   always @(posedge ref_clk) begin
      mem_ack <= 1'b0;
      if (mem_o.req && !mem_ack) begin
         cnt <= cnt + 2'h1;
         if (cnt == lat) begin
            cnt <= 2'h0;
            mem_ack <= 1'b1;
            rd_q <= mem[mem_o.addr[9:2]];
            if (mem_o.we) begin
               mem[mem_o.addr[9:2]] <= mem_o.wdata;
            end
         end
      end
   end
endmodule : dmx_mem_model

// File: dmx_unit_test.sv
// Self-checking bench for the data move, exchange and stack unit
`timescale 1ns/1ns
module data_move_exchange_stack_unit_test;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   dmx_pkg::dmx_mem_t mem_o;
   logic mem_ack;
   logic [31:0] mem_rdata;
   logic [1:0] lat = 2'h0;
   logic lk = 1'b0;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int lock_gap = 0;
   logic [31:0] v;
   logic [31:0] fs [5] = '{32'h0000_0000, 32'h0000_0041, 32'h0000_0080, 32'h0000_0804, 32'h0000_08C0};

   always #25 ref_clk = ~ref_clk;
   dmx_unit DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   dmx_mem_model MEM (.ref_clk(ref_clk), .mem_o(mem_o), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   task automatic print_verdict;
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // A hang is cut short well above the thousand or so cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (lk && mem_o.req && !mem_o.lock) begin
         lock_gap++;
      end
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rc

   function automatic logic [7:0] ga(input int i);
      return {3'h0, i[2:0], 2'h0};
   endfunction : ga

   // Starts one operation and polls the busy bit with a bounded count
   task automatic run(input logic [3:0] op, input logic [3:0] cc, input int dst, input int src, input logic k);
      int n;
      n = 0;
      wr(dmx_pkg::OFF_CMD, {15'h0, k, 2'h0, src[2:0], dst[2:0], cc, op});
      do begin
         rd(dmx_pkg::OFF_STATUS, v);
         n++;
      end while (v[0] !== 1'b0 && n < 40);
      check({31'h0, v[0]}, 32'h0);
   endtask : run

   function automatic logic cnd(input logic [3:0] cc, input logic [31:0] f);
      logic [7:0] t;
      t = {(f[7] ^ f[11]) | f[6], f[7] ^ f[11], f[2], f[7], f[0] | f[6], f[6], f[0], f[11]};
      return t[cc[3:1]] ^ cc[0];
   endfunction : cnd

   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rc(ga(0), dmx_pkg::GPR_RST);
      rc(dmx_pkg::OFF_FLAGS, dmx_pkg::FLAGS_RST);
      rc(8'h40, 32'h0000_0000);
      wr(ga(0), 32'h1122_3344);
      run(4'h0, 4'h0, 0, 0, 1'b0);
      rc(ga(0), 32'h4433_2211);
      wr(ga(2), 32'h0000_00AA);
      for (int k = 0; k < 5; k++) begin
         for (int c = 0; c < 16; c++) begin
            wr(dmx_pkg::OFF_FLAGS, fs[k]);
            wr(ga(1), 32'h0000_0000);
            run(4'h1, c[3:0], 1, 2, 1'b0);
            rc(ga(1), cnd(c[3:0], fs[k]) ? 32'h0000_00AA : 32'h0000_0000);
         end
      end
      wr(dmx_pkg::OFF_FLAGS, 32'h0000_0000);
      wr(ga(1), 32'hFFFF_FFFF);
      wr(ga(2), 32'h0000_0001);
      run(4'h2, 4'h0, 1, 2, 1'b0);
      rc(ga(1), 32'h0000_0000);
      rc(ga(2), 32'hFFFF_FFFF);
      rc(dmx_pkg::OFF_FLAGS, 32'h0000_0055);
      wr(ga(0), 32'h1234_0080);
      run(4'h9, 4'h0, 0, 0, 1'b0);
      rc(ga(0), 32'h1234_FF80);
      run(4'hA, 4'h0, 0, 0, 1'b0);
      rc(ga(0), 32'hFFFF_FF80);
      wr(ga(0), 32'hFFFF_FF7F);
      run(4'h9, 4'h0, 0, 0, 1'b0);
      rc(ga(0), 32'hFFFF_007F);
      lat <= 2'h2;
      wr(ga(4), 32'h0000_0100);
      wr(ga(3), 32'hCAFE_0001);
      run(4'h5, 4'h0, 0, 3, 1'b0);
      rc(ga(4), 32'h0000_00FC);
      check(MEM.mem[63], 32'hCAFE_0001);
      run(4'h6, 4'h0, 5, 0, 1'b0);
      rc(ga(5), 32'hCAFE_0001);
      rc(ga(4), 32'h0000_0100);
      lat <= 2'h0;
      for (int i = 0; i < 8; i++) begin
         if (i != 4) begin
            wr(ga(i), 32'h10 + i);
         end
      end
      run(4'h7, 4'h0, 0, 0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         check(MEM.mem[63 - i], (i == 4) ? 32'h0000_0100 : 32'h10 + i);
      end
      rc(ga(4), 32'h0000_00E0);
      // The skipped slot gets a value no register should ever receive
      MEM.mem[59] = 32'h0000_5555;
      for (int i = 0; i < 8; i++) begin
         if (i != 4) begin
            wr(ga(i), 32'h0000_0000);
         end
      end
      lat <= 2'h1;
      run(4'h8, 4'h0, 0, 0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         rc(ga(i), (i == 4) ? 32'h0000_0100 : 32'h10 + i);
      end
      MEM.mem[32] = 32'h0000_0077;
      wr(dmx_pkg::OFF_MADDR, 32'h0000_0080);
      wr(ga(0), 32'h0000_0077);
      wr(ga(1), 32'h0000_0099);
      lk = 1'b1;
      run(4'h3, 4'h0, 0, 1, 1'b1);
      check(MEM.mem[32], 32'h0000_0099);
      rc(dmx_pkg::OFF_STATUS, 32'h0000_0004);
      rc(dmx_pkg::OFF_FLAGS, 32'h0000_0044);
      run(4'h3, 4'h0, 0, 1, 1'b1);
      rc(ga(0), 32'h0000_0099);
      check(MEM.mem[32], 32'h0000_0099);
      rc(dmx_pkg::OFF_FLAGS, 32'h0000_0095);
      MEM.mem[34] = 32'h0000_1111;
      MEM.mem[35] = 32'h0000_2222;
      wr(dmx_pkg::OFF_MADDR, 32'h0000_0088);
      wr(ga(0), 32'h0000_1111);
      wr(ga(2), 32'h0000_2222);
      wr(ga(3), 32'h0000_B0B0);
      wr(ga(1), 32'h0000_C0C0);
      run(4'h4, 4'h0, 0, 0, 1'b1);
      check(MEM.mem[34], 32'h0000_B0B0);
      check(MEM.mem[35], 32'h0000_C0C0);
      run(4'h4, 4'h0, 0, 0, 1'b1);
      rc(ga(0), 32'h0000_B0B0);
      rc(ga(2), 32'h0000_C0C0);
      check(32'(lock_gap), 32'h0000_0000);
      print_verdict();
   end
endmodule : data_move_exchange_stack_unit_test
